//--- hdl/sir_pkg.sv
// constants and carrier types for the two-wire register slave.
// assumes a single 10 MHz clock and bus pins sampled synchronously.
//
// Behaviour
// - accept send, receive, read and write byte plus unlimited block read/write
// - serial-select input is ignored entirely in two-wire mode
// - no answer to bus traffic for 15 ms after reset
// - never hold the clock low; tolerate long host low phases
// - data falling while clock high marks a start
// - first byte is 7-bit address then direction, one means read
// - bytes are eight bits, most significant first, both ways
// - acknowledge own address and every register or data byte by pulling data low on ninth clock
// - data rising while clock high is a stop; slave returns to idle
// - with timeouts on, clock low for 30 ms resets the slave
// - both timeouts are off until the enable input is set
// - with timeouts on, both lines high over 200 us resets the slave
// - works at bus clocks from 10 kHz up to 400 kHz
// - block transfers carry no count; they run until the host stops
// - write byte: address, register, data, stop; data stored at register
// - read byte: register write, repeated start, read one byte, nack, stop
// - register byte then stop only loads the pointer
// - pointer-only write and address-less read do nothing in deepest sleep
// - read without register phase returns pointer byte, pointer not advanced
// - block write advances the pointer after each stored byte, wrapping
// - block read advances the pointer after each byte, sends while acked
// - bus address taken from the strap at start-up, five codes
package sir_pkg;

    // ==================================================
    // timing
    localparam int SIR_CLK_PERIOD_NS = 100;
    localparam int SIR_QUIET_TIME_MS = 15;
    localparam int SIR_LOW_TIMEOUT_MS = 30;
    localparam int SIR_IDLE_TIME_US = 200;
    localparam int SIR_QUIET_CYCLES = SIR_QUIET_TIME_MS * 1_000_000 / SIR_CLK_PERIOD_NS;
    localparam int SIR_LOW_CYCLES = SIR_LOW_TIMEOUT_MS * 1_000_000 / SIR_CLK_PERIOD_NS;
    localparam int SIR_IDLE_CYCLES = SIR_IDLE_TIME_US * 1_000 / SIR_CLK_PERIOD_NS;

    // ==================================================
    // addressing
    localparam logic [6:0] SIR_ADDR_BASE = 7'h28;
    localparam logic [2:0] SIR_STRAP_MAX = 3'h4;
    localparam logic [7:0] SIR_PTR_RESET = 8'h00;
    localparam logic [3:0] SIR_BYTE_BITS = 4'h8;

    // ==================================================
    // carriers
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } sir_bus_ev_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } sir_wr_t;

    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_reg,
        st_reg_ack,
        st_wdata,
        st_wdata_ack,
        st_rdata,
        st_rack,
        st_ignore
    } sir_state_t;

endpackage

//--- hdl/sir_bus_cond.sv
// start, stop and clock edge detection on the two bus lines.
// assumes pin levels already synchronous to clk_i.
module sir_bus_cond
    import sir_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output sir_bus_ev_t ev_o
);

    logic scl_reg;
    logic sda_reg;

    // ==================================================
    // previous levels, idle high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else
        begin
            scl_reg <= scl_i;
            sda_reg <= sda_i;
        end
    end

    // ==================================================
    // conditions
    always_comb
    begin
        ev_o.start = scl_i & scl_reg & sda_reg & ~sda_i;
        ev_o.stop = scl_i & scl_reg & ~sda_reg & sda_i;
        ev_o.scl_rise = scl_i & ~scl_reg;
        ev_o.scl_fall = ~scl_i & scl_reg;
        ev_o.sda = sda_i;
    end

endmodule

//--- hdl/sir_timer.sv
// saturating run-length timer: expired_o is high once run_i has held
// for LIMIT consecutive cycles, and drops on the clock after run_i drops.
module sir_timer
    import sir_pkg::*;
#(
    parameter int LIMIT = 2000
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic expired_o
);

    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] cnt_reg;

    if (LIMIT < 1)
    begin : g_chk
        $error("sir_timer: LIMIT must be at least 1");
    end

    // ==================================================
    // counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
            cnt_reg <= '0;
        else if (cnt_reg != CW'(LIMIT))
            cnt_reg <= cnt_reg + CW'(1);
    end

    assign expired_o = (cnt_reg == CW'(LIMIT));

endmodule

//--- hdl/sir_slave.sv
// two-wire register slave: byte access to an 8-bit register space.
// the register space sits outside; it must give rd_data_i for rd_addr_o
// combinationally, and takes writes from the one-cycle wr_o strobe.
module sir_slave
    import sir_pkg::*;
#(
    parameter int QUIET_CYCLES = SIR_QUIET_CYCLES,
    parameter int LOW_CYCLES = SIR_LOW_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic two_wire_clock_pin_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic serial_select_i,
    input wire logic [2:0] address_strap_pin_i,
    input wire logic timeout_en_i,
    input wire logic deepest_sleep_flag_i,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output sir_wr_t wr_o
);

    if (QUIET_CYCLES < 1 || LOW_CYCLES < 1)
    begin : g_chk
        $error("sir_slave: timing counts must be at least 1");
    end

    sir_bus_ev_t ev;
    sir_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic sda_oe_reg;
    logic [7:0] ptr_reg;
    logic [7:0] back_reg;
    logic ptr_only_reg;
    logic had_reg_reg;
    logic strap_done_reg;
    logic strap_ok_reg;
    logic [6:0] own_addr_reg;
    sir_wr_t wr_reg;
    logic quiet_done;
    logic low_exp;
    logic idle_exp;
    logic bus_reset;
    logic byte_end;
    logic addr_hit;
    logic take_start;

    // ==================================================
    // bus conditions and timers
    sir_bus_cond u_cond (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(two_wire_clock_pin_i),
        .sda_i(sda_i),
        .ev_o(ev)
    );

    sir_timer #(.LIMIT(QUIET_CYCLES)) u_quiet (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(1'b1),
        .expired_o(quiet_done)
    );

    // timers only run with the enable set, so they are inert after reset
    sir_timer #(.LIMIT(LOW_CYCLES)) u_low (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(timeout_en_i & ~two_wire_clock_pin_i),
        .expired_o(low_exp)
    );

    sir_timer #(.LIMIT(SIR_IDLE_CYCLES)) u_idle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(timeout_en_i & two_wire_clock_pin_i & sda_i),
        .expired_o(idle_exp)
    );

    // ==================================================
    // decode
    // serial_select_i is deliberately not read in this mode
    assign bus_reset = ev.stop | (timeout_en_i & (low_exp | idle_exp));
    assign byte_end = ev.scl_fall && (cnt_reg == SIR_BYTE_BITS);
    assign take_start = ev.start && quiet_done;
    assign addr_hit = strap_ok_reg && (shift_reg[7:1] == own_addr_reg)
        && !(shift_reg[0] && !had_reg_reg && deepest_sleep_flag_i);

    // ==================================================
    // strap capture, one clock after reset release
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strap_done_reg <= 1'b0;
            strap_ok_reg <= 1'b0;
            own_addr_reg <= SIR_ADDR_BASE;
        end
        else if (!strap_done_reg)
        begin
            strap_done_reg <= 1'b1;
            strap_ok_reg <= (address_strap_pin_i <= SIR_STRAP_MAX);
            own_addr_reg <= SIR_ADDR_BASE + {4'h0, address_strap_pin_i};
        end
    end

    // ==================================================
    // protocol state, bit count and shifter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || bus_reset)
        begin
            state_reg <= st_idle;
            cnt_reg <= '0;
            if (rst_i)
                shift_reg <= '0;
        end
        else if (take_start)
        begin
            state_reg <= st_addr;
            cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                st_addr, st_reg, st_wdata:
                begin
                    if (ev.scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], ev.sda};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (byte_end)
                    begin
                        if (state_reg == st_addr)
                            state_reg <= addr_hit ? st_addr_ack : st_ignore;
                        else if (state_reg == st_reg)
                            state_reg <= st_reg_ack;
                        else
                            state_reg <= st_wdata_ack;
                    end
                end
                st_addr_ack:
                begin
                    if (ev.scl_fall)
                    begin
                        cnt_reg <= '0;
                        if (shift_reg[0])
                        begin
                            state_reg <= st_rdata;
                            shift_reg <= rd_data_i;
                        end
                        else
                            state_reg <= st_reg;
                    end
                end
                st_reg_ack, st_wdata_ack:
                begin
                    // data bytes repeat until the host stops
                    if (ev.scl_fall)
                    begin
                        state_reg <= st_wdata;
                        cnt_reg <= '0;
                    end
                end
                st_rdata:
                begin
                    if (ev.scl_rise)
                        cnt_reg <= cnt_reg + 4'h1;
                    if (ev.scl_fall && cnt_reg != 4'h0)
                    begin
                        if (cnt_reg == SIR_BYTE_BITS)
                        begin
                            state_reg <= st_rack;
                            cnt_reg <= '0;
                        end
                        else
                            shift_reg <= {shift_reg[6:0], 1'b0};
                    end
                end
                st_rack:
                begin
                    // count 1 marks a host acknowledge seen on this clock
                    if (ev.scl_rise)
                    begin
                        if (ev.sda)
                            state_reg <= st_ignore;
                        else
                            cnt_reg <= 4'h1;
                    end
                    if (ev.scl_fall && cnt_reg == 4'h1)
                    begin
                        state_reg <= st_rdata;
                        cnt_reg <= '0;
                        shift_reg <= rd_data_i;
                    end
                end
                st_idle, st_ignore:
                    state_reg <= state_reg;
                default:
                    state_reg <= st_idle;
            endcase
        end
    end

    // ==================================================
    // data line drive; changes on clock falls, and is released at start, stop or timeout. the clock line has
    // no driver at all, so the host alone sets its low time
    always_ff @(posedge clk_i)
    begin
        if (rst_i || bus_reset || take_start)
            sda_oe_reg <= 1'b0;
        else
        begin
            case (state_reg)
                st_addr:
                    if (byte_end && addr_hit)
                        sda_oe_reg <= 1'b1;
                st_reg, st_wdata:
                    if (byte_end)
                        sda_oe_reg <= 1'b1;
                st_addr_ack:
                    if (ev.scl_fall)
                        sda_oe_reg <= shift_reg[0] & ~rd_data_i[7];
                st_reg_ack, st_wdata_ack:
                    if (ev.scl_fall)
                        sda_oe_reg <= 1'b0;
                st_rdata:
                    if (ev.scl_fall && cnt_reg != 4'h0)
                        sda_oe_reg <= (cnt_reg == SIR_BYTE_BITS) ? 1'b0 : ~shift_reg[6];
                st_rack:
                    if (ev.scl_fall && cnt_reg == 4'h1)
                        sda_oe_reg <= ~rd_data_i[7];
                default:
                    sda_oe_reg <= 1'b0;
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_reg;

    // ==================================================
    // register phase seen in this transaction
    always_ff @(posedge clk_i)
    begin
        if (rst_i || bus_reset)
            had_reg_reg <= 1'b0;
        else if (state_reg == st_reg && byte_end)
            had_reg_reg <= 1'b1;
    end

    // ==================================================
    // address pointer; a bare register byte is undone at stop in sleep
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_reg <= SIR_PTR_RESET;
            back_reg <= SIR_PTR_RESET;
            ptr_only_reg <= 1'b0;
        end
        else if (bus_reset)
        begin
            if (ptr_only_reg && deepest_sleep_flag_i)
                ptr_reg <= back_reg;
            ptr_only_reg <= 1'b0;
        end
        else if (take_start)
            ptr_only_reg <= 1'b0;
        else if (state_reg == st_reg && byte_end)
        begin
            back_reg <= ptr_reg;
            ptr_reg <= shift_reg;
            ptr_only_reg <= 1'b1;
        end
        else if (state_reg == st_wdata && byte_end)
        begin
            ptr_reg <= ptr_reg + 8'h01;
            ptr_only_reg <= 1'b0;
        end
        else if (state_reg == st_rack && ev.scl_rise && had_reg_reg)
            ptr_reg <= ptr_reg + 8'h01;
    end

    assign rd_addr_o = ptr_reg;

    // ==================================================
    // register write strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wr_reg <= '0;
        else
        begin
            wr_reg.en <= 1'b0;
            if (state_reg == st_wdata && byte_end)
            begin
                wr_reg.en <= 1'b1;
                wr_reg.addr <= ptr_reg;
                wr_reg.data <= shift_reg;
            end
        end
    end

    assign wr_o = wr_reg;

    // ==================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_addr_end;
        state_reg == st_addr && byte_end && !bus_reset;
    endsequence

    sequence s_held_reg;
        state_reg == st_reg && !timeout_en_i && !ev.start && !ev.stop && !ev.scl_rise && !ev.scl_fall;
    endsequence

    property p_addr_ack;
        s_addr_end ##0 addr_hit |=> sda_oe_o && state_reg == st_addr_ack;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("matched address not acknowledged");

    property p_addr_nack;
        s_addr_end ##0 !addr_hit |=> !sda_oe_o && state_reg == st_ignore;
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

    property p_sleep_rd;
        s_addr_end ##0 (shift_reg[0] && !had_reg_reg && deepest_sleep_flag_i) |=> !sda_oe_o;
    endproperty
    a_sleep_rd: assert property (p_sleep_rd) else $error("address-less read answered in sleep");

    property p_stop;
        ev.stop |=> state_reg == st_idle && !sda_oe_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not idle the slave");

    property p_start;
        take_start && !bus_reset |=> state_reg == st_addr && cnt_reg == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_quiet;
        !quiet_done |-> !sda_oe_o && state_reg == st_idle;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus answered during power-up quiet time");

    property p_wr_pulse;
        wr_reg.en |=> !wr_reg.en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

    property p_blk_inc;
        wr_reg.en |-> ptr_reg == 8'(wr_reg.addr + 8'h01);
    endproperty
    a_blk_inc: assert property (p_blk_inc) else $error("pointer not advanced after write");

    property p_tmo_off;
        s_held_reg |=> state_reg == st_reg;
    endproperty
    a_tmo_off: assert property (p_tmo_off) else $error("transfer lost with timeouts disabled");

    property p_low_tmo;
        timeout_en_i && low_exp |=> state_reg == st_idle && !sda_oe_o;
    endproperty
    a_low_tmo: assert property (p_low_tmo) else $error("clock-low timeout did not reset");

    property p_rx_hold;
        state_reg == st_rack && ev.scl_rise && !had_reg_reg && !bus_reset |=> $stable(ptr_reg);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("pointer moved on address-less read");

endmodule

//--- test/sir_host_model.sv
// host controller model for the two-wire register slave: drives the clock
// line and an open-drain data driver; reads the wired data level back.
// assumes the bench wires data as the and of all drivers with a pull-up.
module sir_host_model
(
    input wire logic clk_i,
    input wire logic sda_w_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==================================================
    // timing knobs, set by the bench between transfers
    int hp = 12;
    int low_ext = 0;
    int high_ext = 0;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ==================================================
    // bus conditions
    task automatic start_cond();
        sda_o <= 1'b1;
        wait_clk(hp);
        scl_o <= 1'b1;
        wait_clk(hp);
        sda_o <= 1'b0;
        wait_clk(hp);
        scl_o <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond();
        sda_o <= 1'b0;
        wait_clk(hp);
        scl_o <= 1'b1;
        wait_clk(hp);
        sda_o <= 1'b1;
        wait_clk(hp);
    endtask

    // data changes only two cycles after the clock fall, so the slave never
    // sees a data edge while the clock is high inside a byte
    task automatic bit_x(input logic b, output logic r);
        sda_o <= b;
        wait_clk(hp + low_ext);
        low_ext = 0;
        scl_o <= 1'b1;
        wait_clk(hp / 2 + high_ext);
        high_ext = 0;
        r = sda_w_i;
        wait_clk(hp - hp / 2);
        scl_o <= 1'b0;
        wait_clk(2);
    endtask

    // eight bits most significant first, then the ninth bit
    task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                        output logic ack_rx);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_tx, ack_rx);
    endtask
endmodule

//--- test/sir_slave_test.sv
// self-checking bench for the two-wire register slave.
// assumes the host model beside it and a register space held here.
module sir_slave_test
    import sir_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==================================================
    // signals
    localparam int QUIET = 20;
    localparam logic [7:0] AW = {SIR_ADDR_BASE, 1'b0};
    localparam logic [7:0] AR = {SIR_ADDR_BASE, 1'b1};
    logic clk_i;
    logic rst_i = 1'b1;
    logic scl;
    logic host_sda;
    logic sda_w;
    logic sda_dut;
    logic oe;
    logic sel = 1'b0;
    logic [2:0] strap = 3'h0;
    logic ten = 1'b0;
    logic sleep = 1'b0;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    sir_wr_t wr;
    logic [7:0] regs [256];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    assign sda_w = host_sda & (sda_dut | ~oe);
    assign rd_data = regs[rd_addr];

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
        for (int i = 0; i < 256; i++) regs[i] = 8'h00;

    always @(posedge clk_i)
        if (wr.en === 1'b1) regs[wr.addr] <= wr.data;

    // select input keeps moving to show it has no effect
    always @(posedge clk_i) sel <= ~sel;

    sir_slave #(.QUIET_CYCLES(QUIET), .LOW_CYCLES(200)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .two_wire_clock_pin_i(scl), .sda_i(sda_w), .sda_o(sda_dut),
        .sda_oe_o(oe), .serial_select_i(sel), .address_strap_pin_i(strap), .timeout_en_i(ten),
        .deepest_sleep_flag_i(sleep), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_o(wr));

    sir_host_model u_host (.clk_i(clk_i), .sda_w_i(sda_w), .scl_o(scl), .sda_o(host_sda));

    // ==================================================
    // helpers
    task automatic stop_test();
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp_nack);
        logic [7:0] rx;
        logic a;
        u_host.xfer(b, 1'b1, rx, a);
        chk({7'h00, a}, {7'h00, exp_nack});
    endtask

    task automatic rd(input logic host_nack, input logic [7:0] exp);
        logic [7:0] rx;
        logic a;
        u_host.xfer(8'hFF, host_nack, rx, a);
        chk(rx, exp);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (QUIET + 10) @(posedge clk_i);
    endtask

    // ==================================================
    // scenarios
    task automatic t_quiet();
        // a short half period puts the start well inside the quiet time
        u_host.hp = 4;
        rst_i <= 1'b0;
        u_host.start_cond();
        send(AW, 1'b1);
        u_host.stop_cond();
        u_host.hp = 12;
    endtask

    task automatic t_strap();
        for (int c = 0; c < 6; c++)
        begin
            strap <= 3'(c);
            do_reset();
            u_host.start_cond();
            send({SIR_ADDR_BASE + 7'(c), 1'b0}, c > 4);
            u_host.stop_cond();
        end
        strap <= 3'h0;
        do_reset();
    endtask

    task automatic t_byte();
        u_host.hp = 500;
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'h10, 1'b0);
        send(8'hA5, 1'b0);
        u_host.stop_cond();
        u_host.hp = 12;
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'h10, 1'b0);
        u_host.start_cond();
        send(AR, 1'b0);
        rd(1'b1, 8'hA5);
        u_host.stop_cond();
        chk(rd_addr, 8'h11);
    endtask

    task automatic t_block();
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'hFE, 1'b0);
        send(8'hAA, 1'b0);
        send(8'hBB, 1'b0);
        send(8'hCC, 1'b0);
        u_host.stop_cond();
        chk(regs[8'h00], 8'hCC);
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'hFE, 1'b0);
        u_host.start_cond();
        send(AR, 1'b0);
        rd(1'b0, 8'hAA);
        rd(1'b0, 8'hBB);
        rd(1'b1, 8'hCC);
        u_host.stop_cond();
        chk(rd_addr, 8'h01);
    endtask

    task automatic t_pointer();
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'h10, 1'b0);
        u_host.stop_cond();
        chk(rd_addr, 8'h10);
        repeat (2)
        begin
            u_host.start_cond();
            send(AR, 1'b0);
            rd(1'b1, 8'hA5);
            u_host.stop_cond();
        end
        chk(rd_addr, 8'h10);
    endtask

    task automatic t_sleep();
        sleep <= 1'b1;
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'h20, 1'b0);
        u_host.stop_cond();
        chk(rd_addr, 8'h10);
        u_host.start_cond();
        send(AR, 1'b1);
        u_host.stop_cond();
        u_host.start_cond();
        send(AW, 1'b0);
        send(8'h10, 1'b0);
        u_host.start_cond();
        send(AR, 1'b0);
        rd(1'b1, 8'hA5);
        u_host.stop_cond();
        sleep <= 1'b0;
    endtask

    task automatic t_mismatch();
        u_host.start_cond();
        send(AW ^ 8'h02, 1'b1);
        send(AW, 1'b1);
        u_host.stop_cond();
        u_host.start_cond();
        send(AW, 1'b0);
        u_host.stop_cond();
    endtask

    // long low phase, then long high phase with data high, in mid-transfer
    task automatic t_timeout(input logic en);
        ten <= en;
        u_host.start_cond();
        send(AW, 1'b0);
        u_host.low_ext = 300;
        send(8'h30, en);
        u_host.stop_cond();
        u_host.start_cond();
        send(AW, 1'b0);
        u_host.high_ext = 2100;
        send(8'hB0, en);
        u_host.stop_cond();
    endtask

    // ==================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        t_quiet();
        t_strap();
        t_byte();
        t_block();
        t_pointer();
        t_sleep();
        t_mismatch();
        t_timeout(1'b0);
        t_timeout(1'b1);
        stop_test();
    end
endmodule
